// [verilog/nsf_device.sv]
// device end: takes queued set-features commands and reports acceptance and completion
`timescale 1ns/1ps
// Summary of operation
// - low feature nibble 5h selects set-features
// - previous feature byte holds high field
// - slot number sits in count bits 7:3
// - host keeps slot numbers unique while outstanding
// - slot number never above advertised queue depth
// - value bits 7:0 in previous count
// - value bits 15:8 in cylinder low
// - value bits 23:16 in cylinder high
// - value bits 27:24 in sector number
// - completions sent as bits FIS, interrupt set
// - bitmap marks every slot finished since last
// - success shows failure flag and error zero
// - acceptance shown by clearing pending flag
// - early failure: register FIS, failure set, pending clear
// - early failure carries its error code
module nsf_device
    import nsf_pkg::*;
#(
    parameter int MAX_TAG = NSF_MAX_TAG_DEFAULT
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    nsf_link_if.device lnk,
    output logic feat_valid_out,
    output logic [4:0] feat_tag_out,
    output logic [3:0] feat_spec_out,
    output logic [7:0] feat_high_out,
    output logic [27:0] feat_value_out,
    input wire logic feat_done_in,
    input wire logic [4:0] feat_done_tag_in,
    output logic [31:0] active_slots_out,
    output logic [7:0] condition_flags_reg_out,
    output logic [7:0] fault_code_reg_out
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        nsf_dev_state_t st;
        logic cmd_ready;
        logic reg_valid;
        logic [7:0] reg_status;
        logic [7:0] reg_error;
        logic sdb_valid;
        logic [31:0] sdb_bitmap;
        logic [31:0] active;
        logic [31:0] finished;
        logic feat_valid;
        logic [4:0] feat_tag;
        logic [3:0] feat_spec;
        logic [7:0] feat_high;
        logic [27:0] feat_value;
        logic [7:0] cond_flags;
        logic [7:0] fault_code;
    } nsf_dev_regs_t;

    localparam logic [4:0] TAG_LIMIT = 5'(MAX_TAG);

    localparam nsf_dev_regs_t DEV_RESET = '{
        st: NSF_DEV_IDLE,
        cmd_ready: 1'b1,
        reg_valid: 1'b0,
        reg_status: NSF_STATUS_RESET,
        reg_error: NSF_ERROR_RESET,
        sdb_valid: 1'b0,
        sdb_bitmap: NSF_BITMAP_RESET,
        active: NSF_BITMAP_RESET,
        finished: NSF_BITMAP_RESET,
        feat_valid: 1'b0,
        feat_tag: 5'h00,
        feat_spec: 4'h0,
        feat_high: 8'h00,
        feat_value: 28'h0000000,
        cond_flags: NSF_STATUS_RESET,
        fault_code: NSF_ERROR_RESET
    };

    nsf_dev_regs_t s_q;
    nsf_dev_regs_t s_d;

    logic opcode_hit;
    logic sub_hit;
    logic [3:0] cmd_spec;
    logic [7:0] cmd_high;
    logic [4:0] cmd_tag;
    logic [27:0] cmd_value;

    // ************************************************************
    // field unpacking
    // ************************************************************
    nsf_cmd_unpack u_unpack (
        .command_in(lnk.h2d_command),
        .feat_cur_in(lnk.h2d_feat_cur),
        .feat_prev_in(lnk.h2d_feat_prev),
        .cnt_cur_in(lnk.h2d_cnt_cur),
        .cnt_prev_in(lnk.h2d_cnt_prev),
        .snum_cur_in(lnk.h2d_snum_cur),
        .cyl_lo_cur_in(lnk.h2d_cyl_lo_cur),
        .cyl_hi_cur_in(lnk.h2d_cyl_hi_cur),
        .opcode_hit_out(opcode_hit),
        .sub_hit_out(sub_hit),
        .spec_out(cmd_spec),
        .high_out(cmd_high),
        .tag_out(cmd_tag),
        .value_out(cmd_value)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [31:0] done_set;
        logic [31:0] fin;
        logic [31:0] act;
        logic cmd_ok;
        done_set = 32'h0;
        fin = 32'h0;
        act = 32'h0;
        cmd_ok = 1'b0;
        s_d = s_q;
        s_d.reg_valid = 1'b0;
        s_d.sdb_valid = 1'b0;
        s_d.feat_valid = 1'b0;

        // a finish on a slot that was never accepted is ignored
        if (feat_done_in) begin
            done_set = nsf_slot_bit(feat_done_tag_in) & s_q.active;
        end
        // bits collected here are only cleared when shipped, so a late finish is kept
        fin = s_q.finished | done_set;
        act = s_q.active & ~done_set;

        // duplicate or out-of-range slots are refused as well, since the
        // bookkeeping would otherwise merge two commands into one bit
        cmd_ok = opcode_hit && sub_hit && (cmd_tag <= TAG_LIMIT)
            && !s_q.active[cmd_tag];

        unique case (s_q.st)
            NSF_DEV_IDLE: begin
                if (lnk.h2d_valid && s_q.cmd_ready) begin
                    s_d.cmd_ready = 1'b0;
                    s_d.st = NSF_DEV_RESP;
                    s_d.reg_valid = 1'b1;
                    if (cmd_ok) begin
                        act = act | nsf_slot_bit(cmd_tag);
                        s_d.reg_status = nsf_status(1'b0);
                        s_d.reg_error = NSF_ERROR_RESET;
                        s_d.feat_valid = 1'b1;
                        s_d.feat_tag = cmd_tag;
                        s_d.feat_spec = cmd_spec;
                        s_d.feat_high = cmd_high;
                        s_d.feat_value = cmd_value;
                    end else begin
                        s_d.reg_status = nsf_status(1'b1);
                        s_d.reg_error = NSF_ERR_CODE_ABORT;
                    end
                    s_d.cond_flags = s_d.reg_status;
                    s_d.fault_code = s_d.reg_error;
                end else if (fin != 32'h0) begin
                    // the register answer takes priority; completions wait until the state is idle again, two cycles later
                    s_d.sdb_valid = 1'b1;
                    s_d.sdb_bitmap = fin;
                    s_d.cond_flags = nsf_status(1'b0);
                    s_d.fault_code = NSF_ERROR_RESET;
                    fin = 32'h0;
                end
            end
            NSF_DEV_RESP: begin
                s_d.st = NSF_DEV_IDLE;
                s_d.cmd_ready = 1'b1;
            end
        endcase

        s_d.finished = fin;
        s_d.active = act;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= DEV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign lnk.h2d_ready = s_q.cmd_ready;
    assign lnk.d2h_reg_valid = s_q.reg_valid;
    assign lnk.d2h_reg_status = s_q.reg_status;
    assign lnk.d2h_reg_error = s_q.reg_error;
    assign lnk.sdb_valid = s_q.sdb_valid;
    assign lnk.sdb_intr = s_q.sdb_valid;
    assign lnk.sdb_status = nsf_status(1'b0);
    assign lnk.sdb_error = NSF_ERROR_RESET;
    assign lnk.sdb_bitmap = s_q.sdb_bitmap;
    assign feat_valid_out = s_q.feat_valid;
    assign feat_tag_out = s_q.feat_tag;
    assign feat_spec_out = s_q.feat_spec;
    assign feat_high_out = s_q.feat_high;
    assign feat_value_out = s_q.feat_value;
    assign active_slots_out = s_q.active;
    assign condition_flags_reg_out = s_q.cond_flags;
    assign fault_code_reg_out = s_q.fault_code;

endmodule : nsf_device

// [verilog/nsf_pkg.sv]
// shared constants, types and helpers for the queued set-features link
package nsf_pkg;

    // ************************************************************
    // command encoding
    // ************************************************************
    localparam logic [7:0] NSF_OPC_NCQ_NONDATA = 8'h63;
    localparam logic [3:0] NSF_SUB_SET_FEATURES = 4'h5;
    localparam logic [7:0] NSF_DEV_HEAD_QUEUED = 8'h40;
    localparam int NSF_TAG_W = 5;
    localparam int NSF_SLOTS = 32;
    localparam int NSF_MAX_TAG_DEFAULT = 31;
    localparam int NSF_SUB_LSB = 0;
    localparam int NSF_SPEC_LSB = 4;
    localparam int NSF_TAG_LSB = 3;

    // ************************************************************
    // status and error byte layout
    // ************************************************************
    localparam int NSF_ST_BSY = 7;
    localparam int NSF_ST_RDY = 6;
    localparam int NSF_ST_ERR = 0;
    localparam int NSF_ER_ABT = 2;
    localparam logic [7:0] NSF_STATUS_RESET = 8'h40;
    localparam logic [7:0] NSF_ERROR_RESET = 8'h00;
    localparam logic [7:0] NSF_ERR_CODE_ABORT = 8'h04;
    localparam logic [31:0] NSF_BITMAP_RESET = 32'h0;

    // ************************************************************
    // state encodings
    // ************************************************************
    typedef enum logic [1:0] {
        NSF_DEV_IDLE = 2'b01,
        NSF_DEV_RESP = 2'b10
    } nsf_dev_state_t;

    typedef enum logic [2:0] {
        NSF_HST_IDLE = 3'b001,
        NSF_HST_SEND = 3'b010,
        NSF_HST_WAIT = 3'b100
    } nsf_hst_state_t;

    // status byte: ready set, pending flag clear, failure flag as given
    function automatic logic [7:0] nsf_status(input logic fail);
        logic [7:0] s;
        s = 8'h00;
        s[NSF_ST_RDY] = 1'b1;
        s[NSF_ST_BSY] = 1'b0;
        s[NSF_ST_ERR] = fail;
        return s;
    endfunction : nsf_status

    function automatic logic [31:0] nsf_slot_bit(input logic [4:0] tag);
        return 32'h1 << tag;
    endfunction : nsf_slot_bit

endpackage : nsf_pkg

// [verilog/nsf_link_if.sv]
// link between the host controller end and the device end
`timescale 1ns/1ps
interface nsf_link_if (
    input wire logic mclk_in
);
    logic h2d_valid;
    logic h2d_ready;
    logic [7:0] h2d_command;
    logic [7:0] h2d_feat_cur;
    logic [7:0] h2d_feat_prev;
    logic [7:0] h2d_cnt_cur;
    logic [7:0] h2d_cnt_prev;
    logic [7:0] h2d_snum_cur;
    logic [7:0] h2d_cyl_lo_cur;
    logic [7:0] h2d_cyl_hi_cur;
    logic [7:0] h2d_dev_head;
    logic d2h_reg_valid;
    logic [7:0] d2h_reg_status;
    logic [7:0] d2h_reg_error;
    logic sdb_valid;
    logic sdb_intr;
    logic [7:0] sdb_status;
    logic [7:0] sdb_error;
    logic [31:0] sdb_bitmap;

    modport host (
        input mclk_in, h2d_ready, d2h_reg_valid, d2h_reg_status, d2h_reg_error,
        input sdb_valid, sdb_intr, sdb_status, sdb_error, sdb_bitmap,
        output h2d_valid, h2d_command, h2d_feat_cur, h2d_feat_prev, h2d_cnt_cur,
        output h2d_cnt_prev, h2d_snum_cur, h2d_cyl_lo_cur, h2d_cyl_hi_cur, h2d_dev_head
    );

    modport device (
        input mclk_in, h2d_valid, h2d_command, h2d_feat_cur, h2d_feat_prev, h2d_cnt_cur,
        input h2d_cnt_prev, h2d_snum_cur, h2d_cyl_lo_cur, h2d_cyl_hi_cur, h2d_dev_head,
        output h2d_ready, d2h_reg_valid, d2h_reg_status, d2h_reg_error,
        output sdb_valid, sdb_intr, sdb_status, sdb_error, sdb_bitmap
    );
endinterface : nsf_link_if

// [verilog/nsf_cmd_unpack.sv]
// splits a received command block into set-features fields
`timescale 1ns/1ps
module nsf_cmd_unpack
    import nsf_pkg::*;
(
    input wire logic [7:0] command_in,
    input wire logic [7:0] feat_cur_in,
    input wire logic [7:0] feat_prev_in,
    input wire logic [7:0] cnt_cur_in,
    input wire logic [7:0] cnt_prev_in,
    input wire logic [7:0] snum_cur_in,
    input wire logic [7:0] cyl_lo_cur_in,
    input wire logic [7:0] cyl_hi_cur_in,
    output logic opcode_hit_out,
    output logic sub_hit_out,
    output logic [3:0] spec_out,
    output logic [7:0] high_out,
    output logic [4:0] tag_out,
    output logic [27:0] value_out
);
    assign opcode_hit_out = (command_in == NSF_OPC_NCQ_NONDATA);
    assign sub_hit_out = (feat_cur_in[NSF_SUB_LSB +: 4] == NSF_SUB_SET_FEATURES);
    assign spec_out = feat_cur_in[NSF_SPEC_LSB +: 4];
    assign high_out = feat_prev_in;
    assign tag_out = cnt_cur_in[NSF_TAG_LSB +: NSF_TAG_W];
    // value bytes: previous count, cylinder low, cylinder high, sector number nibble
    assign value_out = {snum_cur_in[3:0], cyl_hi_cur_in, cyl_lo_cur_in, cnt_prev_in};
endmodule : nsf_cmd_unpack

// [verilog/nsf_host.sv]
// host end: packs set-features requests into queued commands and tracks slots
`timescale 1ns/1ps
module nsf_host
    import nsf_pkg::*;
#(
    parameter int MAX_TAG = NSF_MAX_TAG_DEFAULT
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    nsf_link_if.host lnk,
    input wire logic req_valid_in,
    input wire logic [3:0] req_sub_in,
    input wire logic [3:0] req_spec_in,
    input wire logic [7:0] req_high_in,
    input wire logic [27:0] req_value_in,
    input wire logic [4:0] req_tag_in,
    output logic req_ready_out,
    output logic refused_out,
    output logic accepted_out,
    output logic rejected_out,
    output logic [7:0] err_code_out,
    output logic done_valid_out,
    output logic [31:0] done_bitmap_out,
    output logic [31:0] outstanding_out
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        nsf_hst_state_t st;
        logic req_ready;
        logic refused;
        logic accepted;
        logic rejected;
        logic [7:0] err_code;
        logic done_valid;
        logic [31:0] done_bitmap;
        logic [31:0] outstanding;
        logic [4:0] tag;
        logic h2d_valid;
        logic [7:0] feat_cur;
        logic [7:0] feat_prev;
        logic [7:0] cnt_cur;
        logic [7:0] cnt_prev;
        logic [7:0] snum_cur;
        logic [7:0] cyl_lo_cur;
        logic [7:0] cyl_hi_cur;
    } nsf_hst_regs_t;

    localparam logic [4:0] TAG_LIMIT = 5'(MAX_TAG);

    nsf_hst_regs_t s_q;
    nsf_hst_regs_t s_d;

    always_comb begin
        logic [31:0] outs;
        outs = s_q.outstanding;
        s_d = s_q;
        s_d.refused = 1'b0;
        s_d.accepted = 1'b0;
        s_d.rejected = 1'b0;
        s_d.done_valid = 1'b0;

        // completions clear first so that a new issue of the same slot wins
        if (lnk.sdb_valid && lnk.sdb_intr) begin
            outs = outs & ~lnk.sdb_bitmap;
            s_d.done_valid = 1'b1;
            s_d.done_bitmap = lnk.sdb_bitmap;
        end

        unique case (s_q.st)
            NSF_HST_IDLE: begin
                if (req_valid_in) begin
                    if (req_tag_in > TAG_LIMIT || s_q.outstanding[req_tag_in]) begin
                        s_d.refused = 1'b1;
                    end else begin
                        s_d.st = NSF_HST_SEND;
                        s_d.req_ready = 1'b0;
                        s_d.h2d_valid = 1'b1;
                        s_d.tag = req_tag_in;
                        s_d.feat_cur = {req_spec_in, req_sub_in};
                        s_d.feat_prev = req_high_in;
                        s_d.cnt_cur = {req_tag_in, 3'h0};
                        s_d.cnt_prev = req_value_in[7:0];
                        s_d.cyl_lo_cur = req_value_in[15:8];
                        s_d.cyl_hi_cur = req_value_in[23:16];
                        s_d.snum_cur = {4'h0, req_value_in[27:24]};
                    end
                end
            end
            NSF_HST_SEND: begin
                if (lnk.h2d_ready) begin
                    s_d.h2d_valid = 1'b0;
                    s_d.st = NSF_HST_WAIT;
                end
            end
            NSF_HST_WAIT: begin
                if (lnk.d2h_reg_valid) begin
                    s_d.st = NSF_HST_IDLE;
                    s_d.req_ready = 1'b1;
                    s_d.err_code = lnk.d2h_reg_error;
                    if (lnk.d2h_reg_status[NSF_ST_ERR]) begin
                        s_d.rejected = 1'b1;
                    end else begin
                        s_d.accepted = 1'b1;
                        outs = outs | nsf_slot_bit(s_q.tag);
                    end
                end
            end
        endcase
        s_d.outstanding = outs;
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= '{st: NSF_HST_IDLE, req_ready: 1'b1, err_code: NSF_ERROR_RESET, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign lnk.h2d_valid = s_q.h2d_valid;
    assign lnk.h2d_command = NSF_OPC_NCQ_NONDATA;
    assign lnk.h2d_feat_cur = s_q.feat_cur;
    assign lnk.h2d_feat_prev = s_q.feat_prev;
    assign lnk.h2d_cnt_cur = s_q.cnt_cur;
    assign lnk.h2d_cnt_prev = s_q.cnt_prev;
    assign lnk.h2d_snum_cur = s_q.snum_cur;
    assign lnk.h2d_cyl_lo_cur = s_q.cyl_lo_cur;
    assign lnk.h2d_cyl_hi_cur = s_q.cyl_hi_cur;
    assign lnk.h2d_dev_head = NSF_DEV_HEAD_QUEUED;
    assign req_ready_out = s_q.req_ready;
    assign refused_out = s_q.refused;
    assign accepted_out = s_q.accepted;
    assign rejected_out = s_q.rejected;
    assign err_code_out = s_q.err_code;
    assign done_valid_out = s_q.done_valid;
    assign done_bitmap_out = s_q.done_bitmap;
    assign outstanding_out = s_q.outstanding;

endmodule : nsf_host

// [tb/nsf_link_asserts.sv]
// concurrent checks on the link between host end and device end
`timescale 1ns/1ps
module nsf_link_asserts (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic h2d_valid,
    input wire logic h2d_ready,
    input wire logic [7:0] h2d_command,
    input wire logic [7:0] h2d_cnt_cur,
    input wire logic [7:0] h2d_dev_head,
    input wire logic d2h_reg_valid,
    input wire logic [7:0] d2h_reg_status,
    input wire logic [7:0] d2h_reg_error,
    input wire logic sdb_valid,
    input wire logic sdb_intr,
    input wire logic [7:0] sdb_status,
    input wire logic [7:0] sdb_error,
    input wire logic [31:0] sdb_bitmap
);
    // ************************************************************
    // link properties
    // ************************************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    a_take_answer: assert property (h2d_valid && h2d_ready |=> d2h_reg_valid && !h2d_ready)
        else $error("no register answer after take");
    a_ready_back: assert property (d2h_reg_valid |=> h2d_ready && !d2h_reg_valid)
        else $error("ready not back after answer");
    a_reg_pending: assert property (d2h_reg_valid |-> !d2h_reg_status[7] && d2h_reg_status[6])
        else $error("pending flag set in answer");
    a_fail_code: assert property (d2h_reg_valid && d2h_reg_status[0] |-> d2h_reg_error == 8'h04)
        else $error("failure without abort code");
    a_ok_clean: assert property (d2h_reg_valid && !d2h_reg_status[0] |-> d2h_reg_error == 8'h00)
        else $error("error byte set on success");
    a_sdb_intr: assert property (sdb_valid |-> sdb_intr && sdb_bitmap != 32'h0)
        else $error("completion without interrupt or slots");
    a_intr_match: assert property (sdb_intr == sdb_valid)
        else $error("interrupt bit outside completion");
    a_sdb_clean: assert property (sdb_valid |-> sdb_status == 8'h40 && sdb_error == 8'h00)
        else $error("completion status not clean");
    a_host_frame: assert property (h2d_valid |-> h2d_command == 8'h63 && h2d_dev_head == 8'h40 && h2d_cnt_cur[2:0] == 3'h0)
        else $error("command frame malformed");
    a_valid_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_cnt_cur))
        else $error("command dropped before take");
    c_multi_slot: cover property (sdb_valid && $countones(sdb_bitmap) > 1);
    c_fail_answer: cover property (d2h_reg_valid && d2h_reg_status[0]);
    c_ok_answer: cover property (d2h_reg_valid && !d2h_reg_status[0]);
endmodule : nsf_link_asserts

// [tb/ncq_set_features_subcmd_tb_top.sv]
// self-checking bench for the queued set-features host and device ends
`timescale 1ns/1ps
module ncq_set_features_subcmd_tb_top;
    // ************************************************************
    // signals and instances
    // ************************************************************
    localparam int MAXT = 15;
    logic mclk_in, rstn_in, req_valid_in, done_in;
    logic [3:0] req_sub_in, req_spec_in;
    logic [7:0] req_high_in, err_code_out, flags, fault;
    logic [27:0] req_value_in, f_value;
    logic [4:0] req_tag_in, done_tag, f_tag;
    logic req_ready_out, refused_out, accepted_out, rejected_out, f_valid, dv;
    logic [3:0] f_spec;
    logic [7:0] f_high;
    logic [31:0] outstanding_out, active, exp_out, pend, db, sbm;
    int fails, check_count, seed;
    nsf_link_if lnk (.mclk_in(mclk_in));
    nsf_link_if lnk_b (.mclk_in(mclk_in));
    nsf_host #(.MAX_TAG(MAXT)) nsf_host_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .lnk(lnk.host),
        .req_valid_in(req_valid_in), .req_sub_in(req_sub_in), .req_spec_in(req_spec_in),
        .req_high_in(req_high_in), .req_value_in(req_value_in), .req_tag_in(req_tag_in),
        .req_ready_out(req_ready_out), .refused_out(refused_out), .accepted_out(accepted_out),
        .rejected_out(rejected_out), .err_code_out(err_code_out), .done_valid_out(dv),
        .done_bitmap_out(db), .outstanding_out(outstanding_out));
    nsf_device #(.MAX_TAG(MAXT)) nsf_device_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .lnk(lnk.device), .feat_valid_out(f_valid), .feat_tag_out(f_tag), .feat_spec_out(f_spec),
        .feat_high_out(f_high), .feat_value_out(f_value), .feat_done_in(done_in),
        .feat_done_tag_in(done_tag), .active_slots_out(active), .condition_flags_reg_out(flags),
        .fault_code_reg_out(fault));
    // the second device faces a driver that breaks the command rules on purpose
    nsf_device #(.MAX_TAG(MAXT)) nsf_device_i2 (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .lnk(lnk_b.device), .feat_valid_out(), .feat_tag_out(), .feat_spec_out(),
        .feat_high_out(), .feat_value_out(), .feat_done_in(1'b0), .feat_done_tag_in(5'h00),
        .active_slots_out(), .condition_flags_reg_out(), .fault_code_reg_out());
    nsf_link_asserts nsf_link_asserts_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .h2d_valid(lnk.h2d_valid), .h2d_ready(lnk.h2d_ready), .h2d_command(lnk.h2d_command),
        .h2d_cnt_cur(lnk.h2d_cnt_cur), .h2d_dev_head(lnk.h2d_dev_head),
        .d2h_reg_valid(lnk.d2h_reg_valid), .d2h_reg_status(lnk.d2h_reg_status),
        .d2h_reg_error(lnk.d2h_reg_error), .sdb_valid(lnk.sdb_valid), .sdb_intr(lnk.sdb_intr),
        .sdb_status(lnk.sdb_status), .sdb_error(lnk.sdb_error), .sdb_bitmap(lnk.sdb_bitmap));
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    // 0 refused by host, 1 rejected by device, 2 accepted
    function automatic int outcome(input logic [3:0] sub, input logic [4:0] tag);
        if (tag > MAXT || exp_out[tag] === 1'b1) return 0;
        return (sub == 4'h5) ? 2 : 1;
    endfunction : outcome
    task automatic rst;
        rstn_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        exp_out = 32'h0;
        pend = 32'h0;
        chk({req_ready_out, outstanding_out, flags, fault, lnk.h2d_ready} === {1'b1, 32'h0, 8'h40, 8'h00, 1'b1}, "reset values");
    endtask : rst
    task automatic req(input logic [3:0] sub, input logic [4:0] tag);
        int k;
        int n;
        logic [3:0] sp;
        logic [7:0] hi;
        logic [27:0] v;
        k = outcome(sub, tag);
        sp = 4'($random(seed));
        hi = 8'($random(seed));
        v = 28'($random(seed));
        n = 0;
        req_valid_in <= 1'b1;
        {req_sub_in, req_spec_in, req_high_in, req_value_in, req_tag_in} <= {sub, sp, hi, v, tag};
        @(posedge mclk_in);
        req_valid_in <= 1'b0;
        while (n < 10 && {refused_out, accepted_out, rejected_out} === 3'b000) begin
            @(posedge mclk_in);
            n++;
            if (lnk.h2d_valid === 1'b1)
                chk(k != 0 && {lnk.h2d_feat_cur, lnk.h2d_feat_prev, lnk.h2d_cnt_cur, lnk.h2d_cnt_prev, lnk.h2d_cyl_lo_cur, lnk.h2d_cyl_hi_cur, lnk.h2d_snum_cur} === {sp, sub, hi, tag, 3'h0, v[7:0], v[15:8], v[23:16], 4'h0, v[27:24]}, "link fields");
            if (f_valid === 1'b1)
                chk(k == 2 && {f_tag, f_spec, f_high, f_value} === {tag, sp, hi, v}, "backend fields");
        end
        chk({refused_out, rejected_out, accepted_out} === (3'b100 >> k), "answer kind");
        @(posedge mclk_in);
        if (k == 1)
            chk({err_code_out, flags, fault} === {8'h04, 8'h41, 8'h04}, "abort report");
        if (k == 2)
            chk({flags, fault} === {8'h40, 8'h00}, "success report");
        if (k == 2)
            exp_out = exp_out | (32'h1 << tag);
        chk({outstanding_out, active} === {exp_out, exp_out}, "slot tracking");
    endtask : req
    // finishes each slot in the mask, one per cycle
    task automatic burst(input logic [31:0] m);
        pend = pend | (m & exp_out);
        exp_out = exp_out & ~m;
        for (int i = 0; i < 32; i++) begin
            if (m[i]) begin
                done_in <= 1'b1;
                done_tag <= 5'(i);
                @(posedge mclk_in);
            end
        end
        done_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        chk(pend === 32'h0, "finished slot never reported");
        chk({outstanding_out, active} === {exp_out, exp_out}, "slots not released");
    endtask : burst
    task automatic bcmd(input logic [7:0] op, input logic [3:0] sub, input logic [4:0] tag,
                        input logic fail);
        int n;
        n = 0;
        lnk_b.h2d_valid <= 1'b1;
        {lnk_b.h2d_command, lnk_b.h2d_feat_cur, lnk_b.h2d_cnt_cur} <= {op, 4'h0, sub, tag, 3'h0};
        do begin
            @(posedge mclk_in);
            n++;
        end while (lnk_b.h2d_ready !== 1'b1 && n < 10);
        // the released command line shows the inverse so a stale value cannot pass
        lnk_b.h2d_valid <= 1'b0;
        lnk_b.h2d_command <= ~op;
        @(posedge mclk_in);
        chk({lnk_b.d2h_reg_valid, lnk_b.d2h_reg_status, lnk_b.d2h_reg_error} === {1'b1, 7'h20, fail, fail ? 8'h04 : 8'h00}, "early answer");
        @(posedge mclk_in);
    endtask : bcmd
    task automatic stop_test;
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    // ************************************************************
    // clock, watchdog and main sequence
    // ************************************************************
    always @(posedge mclk_in) begin
        if (dv === 1'b1)
            chk(db === sbm, "done bitmap");
        sbm = lnk.sdb_bitmap;
        if (rstn_in === 1'b1 && lnk.sdb_valid === 1'b1) begin
            chk((lnk.sdb_bitmap & ~pend) === 32'h0, "slot reported twice or never finished");
            pend = pend & ~lnk.sdb_bitmap;
        end
    end
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    initial begin
        repeat (20000) @(posedge mclk_in);
        fails++;
        stop_test();
    end
    initial begin
        logic [31:0] r;
        seed = 30020;
        {rstn_in, req_valid_in, done_in, done_tag} = '0;
        {req_sub_in, req_spec_in, req_high_in, req_value_in, req_tag_in} = '0;
        {lnk_b.h2d_valid, lnk_b.h2d_command, lnk_b.h2d_feat_cur, lnk_b.h2d_cnt_cur} = '0;
        {lnk_b.h2d_feat_prev, lnk_b.h2d_cnt_prev, lnk_b.h2d_snum_cur} = '0;
        {lnk_b.h2d_cyl_lo_cur, lnk_b.h2d_cyl_hi_cur} = '0;
        lnk_b.h2d_dev_head = 8'h40;
        rst();
        req(4'h5, 5'(MAXT));
        req(4'h5, 5'(MAXT));
        req(4'h5, 5'(MAXT + 1));
        req(4'h5, 5'h00);
        req(4'h3, 5'h01);
        burst(32'h0000_8003);
        repeat (50) begin
            r = $random(seed);
            if (r[1:0] != 2'h0)
                req(r[4:2] == 3'h0 ? r[8:5] : 4'h5, r[15:14] == 2'h0 ? r[13:9] : {1'b0, r[12:9]});
            else
                burst(32'($random(seed)) & 32'h0001_ffff);
        end
        for (int s = 0; s < 16; s++)
            bcmd(8'h63, 4'(s), 5'(s), s != 5);
        bcmd(8'h62, 4'h5, 5'h06, 1'b1);
        bcmd(8'h63, 4'h5, 5'h10, 1'b1);
        bcmd(8'h63, 4'h5, 5'h05, 1'b1);
        bcmd(8'h63, 4'h5, 5'h07, 1'b0);
        req(4'h5, 5'h02);
        rst();
        stop_test();
    end
endmodule : ncq_set_features_subcmd_tb_top
